// ### core/pasc_pkg.sv
// Constants, types and carriers shared by the paired-input converter control logic
package pasc_pkg;

	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 12;
	localparam int N_PAIR  = 6;
	localparam int N_IN    = 12;
	localparam int RES_W   = 10;
	localparam int DIV_W   = 3;
	localparam int BUF_AW  = 4;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL  = 10'h300;
	localparam logic [9:0] IDX_STAT  = 10'h306;
	localparam logic [9:0] IDX_JBASE = 10'h308;
	localparam logic [9:0] IDX_TCTL0 = 10'h30A;
	localparam logic [9:0] IDX_TCTL2 = 10'h30E;
	localparam logic [9:0] IDX_BUF0  = 10'h320;
	localparam logic [9:0] IDX_BUF11 = 10'h336;

	localparam logic [15:0] CTRL_RST   = 16'h0009;
	localparam logic [15:0] JBASE_RST  = 16'h0000;
	localparam int          ENABLE_BIT = 15;
	localparam int          DIV_LSB    = 0;
	localparam int          PAIR_INTERRUPT_ENABLE_BIT  = 7;
	localparam int          PEND_BIT   = 6;
	localparam int          SWTRG_BIT  = 5;
	localparam int          HI_PAIR    = 8;
	localparam int          PAIR_SHIFT = 2;

	localparam logic [1:0] SAMPLE_TICKS = 2'h2;
	localparam logic [3:0] BIT_TICKS    = 4'hA;

	// Fastest converter clock: divisor that keeps it at or below the target rate
	localparam int SYS_CLK_KHZ   = 100000;
	localparam int CONV_TGT_KHZ  = 24000;
	localparam int DIV_FOR_TGT_I = (SYS_CLK_KHZ + CONV_TGT_KHZ - 1) / CONV_TGT_KHZ - 1;
	localparam logic [DIV_W-1:0] DIV_FOR_TGT = DIV_W'(DIV_FOR_TGT_I);

	typedef logic [RES_W-1:0] pasc_code_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_CONV_A = 4'h2,
		ST_SAMP_B = 4'h4,
		ST_CONV_B = 4'h8
	} pasc_state_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} pasc_apb_req_t;

	typedef struct packed {
		logic                         wr_en;
		logic [BUF_AW-1:0]            wr_addr;
		pasc_code_t                   wr_data;
	} pasc_buf_wr_t;

endpackage

// ### core/pasc_result_mem.sv
// Result buffer memory with registered read data
`timescale 1ns/1ps
module pasc_result_mem import pasc_pkg::*; (
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	input  wire pasc_buf_wr_t         wr,
	input  wire logic [BUF_AW-1:0]    rd_addr,
	output pasc_code_t                rd_data
);

	typedef struct packed {
		logic [N_IN-1:0][RES_W-1:0] mem;
		pasc_code_t                 rd;
	} pasc_mem_st_t;

	pasc_mem_st_t r;
	pasc_mem_st_t n;

	// Contents are never reset, only the read register
	always_comb begin
		n = r;
		if (wr.wr_en && wr.wr_addr < BUF_AW'(N_IN)) begin
			n.mem[wr.wr_addr] = wr.wr_data;
		end
		n.rd = (rd_addr < BUF_AW'(N_IN)) ? r.mem[rd_addr] : '0;
		if (!reset_n) begin
			n.rd = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		r <= n;
	end

	assign rd_data = r.rd;

endmodule // pasc_result_mem

// ### core/pasc_core.sv
// Paired-input converter sequencer with APB register slave
`timescale 1ns/1ps
module pasc_core import pasc_pkg::*; (
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire pasc_apb_req_t              apb,
	output logic [DATA_W-1:0]               prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [N_PAIR-1:0]          trig,
	input  wire logic [N_IN-1:0][RES_W-1:0] ain,
	output logic                            conv_busy
);

	typedef struct packed {
		logic [15:0]                  ctrl;
		logic [N_PAIR-1:0]            ready;
		logic [15:0]                  jbase;
		logic [N_PAIR-1:0]            pair_interrupt_enable;
		logic [N_PAIR-1:0]            samp_act;
		logic [N_PAIR-1:0][1:0]       samp_cnt;
		logic [N_PAIR-1:0]            pend;
		logic [N_PAIR-1:0][RES_W-1:0] held;
		pasc_state_t                  st;
		logic [2:0]                   cur;
		logic [1:0]                   bsamp_cnt;
		pasc_code_t                   held_b;
		pasc_code_t                   sar;
		logic [3:0]                   bitcnt;
		logic [DIV_W-1:0]             div_cnt;
		logic                         tick;
		pasc_buf_wr_t                 bw;
		logic [DATA_W-1:0]            prdata;
		logic                         pready;
		logic                         pslverr;
		logic                         busy;
	} pasc_core_st_t;

	pasc_core_st_t r;
	pasc_core_st_t n;

	// Lowest-numbered set flag wins
	function automatic logic [2:0] first_set(input logic [N_PAIR-1:0] v);
		logic [2:0] k;
		k = 3'h0;
		for (int i = N_PAIR - 1; i >= 0; i--) begin
			if (v[i]) begin
				k = 3'(i);
			end
		end
		return k;
	endfunction

	// One successive-approximation step, most significant bit first
	function automatic pasc_code_t sar_step(input pasc_code_t s, input logic [3:0] b, input pasc_code_t code);
		pasc_code_t trial;
		trial = s | (RES_W'(1) << b);
		return (code >= trial) ? trial : s;
	endfunction

	logic                 en;
	logic [9:0]           idx;
	logic                 aligned;
	logic                 is_buf;
	logic                 is_tctl;
	logic [9:0]           buf_off;
	logic [9:0]           tctl_off;
	logic [BUF_AW-1:0]    buf_sel;
	logic [1:0]           tctl_sel;
	logic                 hit;
	logic                 commit;
	logic [N_PAIR-1:0]    sw_trig;
	logic [15:0]          jsum;
	logic [15:0]          rd16;
	pasc_code_t           buf_rd;
	pasc_code_t           step_val;

	assign en       = r.ctrl[ENABLE_BIT];
	assign idx      = apb.paddr[ADDR_W-1:2];
	assign aligned  = (apb.paddr[1:0] == 2'h0);
	assign is_buf   = (idx >= IDX_BUF0) && (idx <= IDX_BUF11) && !idx[0];
	assign is_tctl  = (idx >= IDX_TCTL0) && (idx <= IDX_TCTL2) && !idx[0];
	assign buf_off  = idx - IDX_BUF0;
	assign tctl_off = idx - IDX_TCTL0;
	assign buf_sel  = buf_off[BUF_AW:1];
	assign tctl_sel = tctl_off[2:1];
	assign hit      = aligned && (idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_JBASE || is_tctl || is_buf);
	assign commit   = apb.psel && apb.penable && r.pready && apb.pwrite && hit;
	// Priority-encoded pair number, two words per entry, zero when none set
	assign jsum     = r.jbase + ((|r.ready) ? (16'(first_set(r.ready)) << PAIR_SHIFT) : 16'h0000);
	assign step_val = sar_step(r.sar, r.bitcnt, (r.st == ST_CONV_B) ? r.held_b : r.held[r.cur]);

	pasc_result_mem u_mem (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.wr       (r.bw),
		.rd_addr  (buf_sel),
		.rd_data  (buf_rd)
	);

	always_comb begin
		rd16 = 16'h0000;
		if (idx == IDX_CTRL) begin
			rd16 = r.ctrl;
		end else if (idx == IDX_STAT) begin
			rd16 = 16'(r.ready);
		end else if (idx == IDX_JBASE) begin
			rd16 = {jsum[15:1], 1'b0};
		end else if (is_tctl) begin
			rd16[PAIR_INTERRUPT_ENABLE_BIT]          = r.pair_interrupt_enable[2 * tctl_sel];
			rd16[PEND_BIT]           = r.pend[2 * tctl_sel];
			rd16[HI_PAIR+PAIR_INTERRUPT_ENABLE_BIT]  = r.pair_interrupt_enable[2 * tctl_sel + 1];
			rd16[HI_PAIR+PEND_BIT]   = r.pend[2 * tctl_sel + 1];
		end else if (is_buf) begin
			rd16 = 16'(buf_rd);
		end
	end

	always_comb begin
		n          = r;
		n.bw.wr_en = 1'b0;
		n.tick     = 1'b0;
		sw_trig    = '0;

		// Register writes take effect at the completing edge
		if (commit) begin
			if (idx == IDX_CTRL) begin
				n.ctrl = apb.pwdata[15:0];
			end
			if (idx == IDX_STAT) begin
				n.ready = r.ready & apb.pwdata[N_PAIR-1:0];
			end
			if (idx == IDX_JBASE) begin
				n.jbase = {apb.pwdata[15:1], 1'b0};
			end
			if (is_tctl) begin
				n.pair_interrupt_enable[2 * tctl_sel]     = apb.pwdata[PAIR_INTERRUPT_ENABLE_BIT];
				n.pair_interrupt_enable[2 * tctl_sel + 1] = apb.pwdata[HI_PAIR+PAIR_INTERRUPT_ENABLE_BIT];
				sw_trig[2 * tctl_sel]     = apb.pwdata[SWTRG_BIT];
				sw_trig[2 * tctl_sel + 1] = apb.pwdata[HI_PAIR+SWTRG_BIT];
			end
		end

		// Converter clock enable from the divisor field
		if (en) begin
			if (r.div_cnt >= r.ctrl[DIV_LSB +: DIV_W]) begin
				n.div_cnt = '0;
				n.tick    = 1'b1;
			end else begin
				n.div_cnt = r.div_cnt + DIV_W'(1);
			end
		end else begin
			n.div_cnt = '0;
		end

		// Per-pair sample timers
		for (int i = 0; i < N_PAIR; i++) begin
			if (r.samp_act[i]) begin
				if (r.tick) begin
					if (r.samp_cnt[i] == SAMPLE_TICKS - 2'h1) begin
						n.samp_act[i] = 1'b0;
						n.pend[i]     = 1'b1;
						n.held[i]     = ain[2 * i];
					end else begin
						n.samp_cnt[i] = r.samp_cnt[i] + 2'h1;
					end
				end
			end else if (en && (trig[i] || sw_trig[i]) && !r.pend[i]) begin
				n.samp_act[i] = 1'b1;
				n.samp_cnt[i] = 2'h0;
			end
		end

		// Sequencer: even input, second sample, odd input
		case (r.st)
			ST_IDLE: begin
				if (|r.pend) begin
					n.cur    = first_set(r.pend);
					n.st     = ST_CONV_A;
					n.sar    = '0;
					n.bitcnt = 4'(BIT_TICKS - 4'h1);
					n.busy   = 1'b1;
				end
			end
			ST_CONV_A: begin
				if (r.tick) begin
					n.sar = step_val;
					if (r.bitcnt == 4'h0) begin
						n.bw.wr_en    = 1'b1;
						n.bw.wr_addr  = BUF_AW'({r.cur, 1'b0});
						n.bw.wr_data  = step_val;
						n.st          = ST_SAMP_B;
						n.bsamp_cnt   = 2'h0;
					end else begin
						n.bitcnt = r.bitcnt - 4'h1;
					end
				end
			end
			ST_SAMP_B: begin
				if (r.tick) begin
					if (r.bsamp_cnt == SAMPLE_TICKS - 2'h1) begin
						n.held_b = ain[2 * r.cur + 1];
						n.st     = ST_CONV_B;
						n.sar    = '0;
						n.bitcnt = 4'(BIT_TICKS - 4'h1);
					end else begin
						n.bsamp_cnt = r.bsamp_cnt + 2'h1;
					end
				end
			end
			ST_CONV_B: begin
				if (r.tick) begin
					n.sar = step_val;
					if (r.bitcnt == 4'h0) begin
						n.bw.wr_en    = 1'b1;
						n.bw.wr_addr  = BUF_AW'({r.cur, 1'b1});
						n.bw.wr_data  = step_val;
						n.pend[r.cur] = 1'b0;
						n.st          = ST_IDLE;
						n.busy        = 1'b0;
						if (r.pair_interrupt_enable[r.cur]) begin
							n.ready[r.cur] = 1'b1;
						end
					end else begin
						n.bitcnt = r.bitcnt - 4'h1;
					end
				end
			end
			default: begin
				n.st   = ST_IDLE;
				n.busy = 1'b0;
			end
		endcase

		// Off mode holds the sequencer idle and drops all requests
		if (!en) begin
			n.st       = ST_IDLE;
			n.busy     = 1'b0;
			n.pend     = '0;
			n.samp_act = '0;
		end

		// APB: one wait state, answer registered
		if (apb.psel && apb.penable && !r.pready) begin
			n.pready  = 1'b1;
			n.pslverr = !hit;
			n.prdata  = (hit && !apb.pwrite) ? DATA_W'(rd16) : '0;
		end else begin
			n.pready  = 1'b0;
			n.pslverr = 1'b0;
		end

		// Reset restores registers but not the buffer contents
		if (!reset_n) begin
			n.ctrl     = CTRL_RST;
			n.ready    = '0;
			n.jbase    = JBASE_RST;
			n.pair_interrupt_enable    = '0;
			n.samp_act = '0;
			n.samp_cnt = '0;
			n.pend     = '0;
			n.held     = '0;
			n.st       = ST_IDLE;
			n.cur      = '0;
			n.bsamp_cnt = '0;
			n.held_b   = '0;
			n.sar      = '0;
			n.bitcnt   = '0;
			n.div_cnt  = '0;
			n.tick     = 1'b0;
			n.bw       = '0;
			n.prdata   = '0;
			n.pready   = 1'b0;
			n.pslverr  = 1'b0;
			n.busy     = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		r <= n;
	end

	assign prdata    = r.prdata;
	assign pready    = r.pready;
	assign pslverr   = r.pslverr;
	assign conv_busy = r.busy;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	logic jb_read;
	assign jb_read = apb.psel && apb.penable && !apb.pwrite && aligned && idx == IDX_JBASE;

	a_jump_lsb_zero: assert property (jb_read && r.pready |-> prdata[0] == 1'b0)
		else $error("jump-base read returned odd value");
	a_jump_sum_value: assert property (jb_read && !r.pready |=>
		prdata[15:0] == {($past(r.jbase) + ((|$past(r.ready)) ?
		(16'(first_set($past(r.ready))) << 2) : 16'h0000)) >> 1, 1'b0})
		else $error("jump-base read sum wrong");
	a_off_clears_all: assert property (!en |=> r.pend == '0 && r.st == ST_IDLE && r.samp_act == '0)
		else $error("off mode left work pending");
	a_drop_retrigger: assert property (en && |(r.pend & trig & ~r.samp_act) |=>
		(r.samp_act & $past(r.pend & trig & ~r.samp_act)) == '0)
		else $error("retrigger on pending pair accepted");
	a_sample_then_pend: assert property (en && r.samp_act[0] && r.tick && r.samp_cnt[0] == 2'h1 |=> r.pend[0])
		else $error("sample window did not flag pending");
	a_two_tick_window: assert property (en && $rose(r.samp_act[0]) |-> r.samp_cnt[0] == 2'h0)
		else $error("sample window did not start at zero");
	a_ten_bit_store: assert property (en && r.st == ST_CONV_A && r.tick && r.bitcnt == 4'h0 |=>
		r.bw.wr_en && r.st == ST_SAMP_B)
		else $error("first conversion not stored after bit zero");
	a_priority_pick: assert property (en && r.st == ST_IDLE && |r.pend |=> r.cur == first_set($past(r.pend)))
		else $error("pending pair served out of order");
	a_ready_on_done: assert property (en && r.st == ST_CONV_B && r.tick && r.bitcnt == 4'h0 && r.pair_interrupt_enable[r.cur]
		|=> r.ready[$past(r.cur)])
		else $error("ready flag not set on completion");
	a_div_spacing: assert property (en && r.tick && r.ctrl[2:0] != 3'h0 |=> !r.tick)
		else $error("converter clock faster than divisor allows");
	a_reset_values: assert property (@(posedge core_clk) disable iff (1'b0)
		!reset_n |=> r.ctrl == CTRL_RST && r.st == ST_IDLE)
		else $error("reset did not restore registers");

	c_pair_done: cover property (r.st == ST_CONV_B && r.tick && r.bitcnt == 4'h0);
	c_jump_read: cover property (jb_read && r.pready && |r.ready);
	c_two_pending: cover property (r.pend[0] && r.pend[5]);
	c_dropped_trig: cover property (en && r.pend[1] && trig[1]);

endmodule // pasc_core

// ### test/pasc_trig_src.sv
// Trigger source and analog front end model driving the converter inputs
`timescale 1ns/1ps
module pasc_trig_src import pasc_pkg::*; (
	input  wire logic                       core_clk,
	input  wire logic [N_PAIR-1:0]          fire,
	input  wire logic [N_IN-1:0][RES_W-1:0] codes,
	output logic [N_PAIR-1:0]               trig,
	output logic [N_IN-1:0][RES_W-1:0]      ain
);
	// Fires only when commanded, so the trigger rate stays within capability
	always @(posedge core_clk) begin
		trig <= fire;
		ain  <= codes;
	end
endmodule // pasc_trig_src

// ### test/tb_top.sv
// Self-checking testbench for the paired-input converter sequencer
`timescale 1ns/1ps
module tb_top import pasc_pkg::*;;
	logic                       core_clk = 1'b0;
	logic                       reset_n  = 1'b0;
	pasc_apb_req_t              apb      = '0;
	logic [DATA_W-1:0]          prdata;
	logic                       pready;
	logic                       pslverr;
	logic [N_PAIR-1:0]          fire     = '0;
	logic [N_PAIR-1:0]          trig;
	logic [N_IN-1:0][RES_W-1:0] codes    = '0;
	logic [N_IN-1:0][RES_W-1:0] ain;
	logic                       conv_busy;
	logic [31:0]                seed     = 32'h12;
	logic [31:0]                rd;
	logic                       er;
	int                         fail_count = 0;
	int                         num_checks = 0;
	int                         c;
	int                         n;
	logic [RES_W-1:0]           keep;

	always #5 core_clk = ~core_clk;

	pasc_core pasc_core_i (.core_clk(core_clk), .reset_n(reset_n), .apb(apb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trig(trig), .ain(ain), .conv_busy(conv_busy));
	pasc_trig_src pasc_trig_src_i (.core_clk(core_clk), .fire(fire), .codes(codes), .trig(trig), .ain(ain));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		apb.penable <= 1'b1;
		// Request holds until the edge at which pready is seen high; data taken there
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		apb <= '0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask

	task automatic shoot(input logic [N_PAIR-1:0] m, input int h);
		@(posedge core_clk);
		fire <= m;
		repeat (h) @(posedge core_clk);
		fire <= '0;
	endtask

	task automatic busy_len();
		n = 0;
		c = 0;
		while (conv_busy !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		while (conv_busy === 1'b1 && c < 300) begin
			@(negedge core_clk);
			c++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		rdc("ctrl_rst", 12'hC00, 32'h0000_0009);
		rdc("stat_rst", 12'hC18, 32'h0);
		rdc("jb_rst", 12'hC20, 32'h0);
		wr(12'hC20, 32'h0000_0361);
		rdc("jb_lsb", 12'hC20, 32'h0000_0360);
		xfer(1'b0, 12'hC40, 32'h0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		$display("test registers done");
		shoot(6'h01, 1);
		repeat (40) @(posedge core_clk);
		rdc("off_trig", 12'hC18, 32'h0);
		for (int i = 0; i < 3; i++) wr(12'hC28 + 12'(8 * i), 32'h0000_8080);
		rdc("tctl_rw", 12'hC30, 32'h0000_8080);
		for (int d = 0; d < 2; d++) begin
			for (int k = 0; k < N_IN; k++) begin
				seed = xs(seed);
				codes[k] <= seed[RES_W-1:0];
			end
			wr(12'hC00, 32'h0);
			wr(12'hC00, 32'h8000 | d);
			repeat (4) @(posedge core_clk);
			shoot(6'h04, 1);
			busy_len();
			// Idle uses up the tick on its own edge only when every clock ticks
			chk("busy_len", c, (d == 0) ? 22 : 22 * (d + 1) - 1);
			rdc("buf_even", 12'hCA0, {22'h0, codes[4]});
			rdc("buf_odd", 12'hCA8, {22'h0, codes[5]});
			rdc("ready2", 12'hC18, 32'h04);
			rdc("jb_pair2", 12'hC20, 32'h0368);
			wr(12'hC18, 32'h0);
			rdc("ready_clr", 12'hC18, 32'h0);
		end
		$display("test timing done");
		shoot(6'h0A, 8);
		n = 0;
		rd = 0;
		while (rd[5:0] == 6'h0 && n < 40) begin
			xfer(1'b0, 12'hC18, 32'h0);
			n++;
		end
		chk("first_served", rd, 32'h02);
		repeat (60) @(posedge core_clk);
		rdc("both_ready", 12'hC18, 32'h0A);
		rdc("jb_pri", 12'hC20, 32'h0364);
		rdc("jb_keep", 12'hC18, 32'h0A);
		wr(12'hC18, 32'h08);
		rdc("jb_pair3", 12'hC20, 32'h036C);
		busy_len();
		chk("no_retrig", c, 0);
		wr(12'hC18, 32'h0);
		$display("test priority done");
		shoot(6'h01, 1);
		repeat (5) @(posedge core_clk);
		wr(12'hC00, 32'h0001);
		rdc("off_pend", 12'hC28, 32'h0000_8080);
		chk("off_busy", {31'h0, conv_busy}, 32'h0);
		wr(12'hC00, 32'h8001);
		repeat (80) @(posedge core_clk);
		rdc("off_nores", 12'hC18, 32'h0);
		wr(12'hC28, 32'h0000_80A0);
		repeat (60) @(posedge core_clk);
		rdc("sw_trig", 12'hC18, 32'h01);
		rdc("jb_pair0", 12'hC20, 32'h0360);
		wr(12'hC18, 32'h0);
		$display("test off mode done");
		keep = codes[5];
		shoot(6'h04, 1);
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b0;
		@(posedge core_clk);
		reset_n <= 1'b1;
		@(negedge core_clk);
		chk("rst_busy", {31'h0, conv_busy}, 32'h0);
		rdc("rst_ctrl", 12'hC00, 32'h0009);
		rdc("rst_tctl", 12'hC38, 32'h0);
		rdc("rst_buf", 12'hCA8, {22'h0, keep});
		$display("test reset done");
		print_verdict();
	end
endmodule // tb_top
